//--- logic/vamap_map.svh
// Offsets, field positions, reset values and vector slots of the address map.
// Included by the decoder and top design files; definitions only.
`ifndef VAMAP_MAP_SVH
`define VAMAP_MAP_SVH

`define VAMAP_SPACE_BYTES     32768
`define VAMAP_RAM_BYTES       1024
`define VAMAP_HWREG_BYTES     64
`define VAMAP_STACK_LO        16'h0100
`define VAMAP_STACK_HI        16'h017f
`define VAMAP_VEC_BASE        16'hffe0
`define VAMAP_VEC_RSVD_HI     16'hffed
`define VAMAP_VEC_EXT         16'hfff6
`define VAMAP_VEC_SUSP        16'hfff8
`define VAMAP_VEC_FLASH       16'hfffa
`define VAMAP_VEC_TRAP        16'hfffc
`define VAMAP_VEC_RESET       16'hfffe

`define VAMAP_PA_VALUE        8'h00
`define VAMAP_PA_DIR          8'h01
`define VAMAP_PB_VALUE        8'h02
`define VAMAP_PB_DIR          8'h03
`define VAMAP_PC_VALUE        8'h04
`define VAMAP_PC_DIR          8'h05
`define VAMAP_PD_VALUE        8'h06
`define VAMAP_PD_DIR          8'h07
`define VAMAP_CTRL            8'h08
`define VAMAP_STATUS          8'h09
`define VAMAP_VEC_OUT         8'h0a

`define VAMAP_PORT_RST        8'h00
`define VAMAP_PC_RST          8'hf0
`define VAMAP_CTRL_IMASK      0
`define VAMAP_CTRL_HALT       1
`define VAMAP_CTRL_TRAP       2
`define VAMAP_CTRL_ACK        3
`define VAMAP_ST_PEND         0
`define VAMAP_ST_HALT         1
`define VAMAP_ST_SRC_LSB      4

`endif

//--- logic/vamap_pkg.sv
// Types shared by the vector and address map block.
// Used with vamap_map.svh for the numbers.
package vamap_pkg;
  typedef enum logic [2:0] {
    VAMAP_SRC_NONE,
    VAMAP_SRC_EXT,
    VAMAP_SRC_SUSP,
    VAMAP_SRC_FLASH,
    VAMAP_SRC_TRAP,
    VAMAP_SRC_RESET
  } vamap_src_t;

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] dir;
  } vamap_port_t;

  typedef struct packed {
    logic ram;
    logic hwreg;
    logic stack;
    logic vec;
    logic vec_rsvd;
    logic prog;
  } vamap_region_t;
endpackage : vamap_pkg

//--- logic/vamap_decode.sv
// Address region decoder for the 64 Kbyte space (upper half is program space ending in the vectors).
// Purely combinational; the caller registers its outputs.
`timescale 1ns/1ps
`default_nettype none
`include "vamap_map.svh"
module vamap_decode
  import vamap_pkg::*;
#(
  parameter int RAM_BYTES = `VAMAP_RAM_BYTES
) (
  input  wire logic [15:0]   addr,   // Core address
  output var  vamap_region_t region  // Region hits
);
  initial begin
    if (RAM_BYTES < `VAMAP_HWREG_BYTES * 2 || RAM_BYTES > `VAMAP_RAM_BYTES)
      $error("vamap_decode: RAM_BYTES out of range");
  end

  always_comb begin
    region          = '0;
    region.hwreg    = addr < 16'(`VAMAP_HWREG_BYTES);                 // RULE2
    region.ram      = addr < 16'(RAM_BYTES);                          // RULE2
    region.stack    = addr >= `VAMAP_STACK_LO && addr <= `VAMAP_STACK_HI; // RULE3
    region.vec      = addr >= `VAMAP_VEC_BASE;                        // RULE4
    region.vec_rsvd = addr >= `VAMAP_VEC_BASE && addr <= `VAMAP_VEC_RSVD_HI; // RULE4
    // Program space: top 32 K less the 32-byte vector table at its end
    region.prog     = addr[15] && !region.vec;                        // RULE1
  end
endmodule : vamap_decode
`default_nettype wire

//--- logic/vamap_top.sv
// Vector and address map: port registers, region decode, vector selection.
// APB slave at 25 MHz; core supplies addresses and events, software sets halt state.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "vamap_map.svh"
// Contract
// (RULE1) Decode one 32 Kbyte memory and register space
// (RULE2) Up to 1024 RAM bytes, low 64 registers
// (RULE3) Stack at 0100h to 017Fh
// (RULE4) Top 32 bytes vectors, FFE0h-FFEDh unused
// (RULE5) Software never touches reserved locations
// (RULE6) Reset vector FFFEh, unmaskable, leaves halt
// (RULE7) External inputs share FFF6h, maskable, wake
// (RULE8) Suspend end FFF8h, maskable, wakes
// (RULE9) Flash start FFFAh, maskable, wakes
// (RULE10) Trap FFFCh, unmaskable, no wake
// (RULE11) Port A value/direction 0000h/0001h reset 00h
// (RULE12) Port B at 0002h/0003h reset 00h
// (RULE13) Port C at 0004h/0005h reset 1111x000b
// (RULE14) Port D at 0006h/0007h reset 00h
// (RULE15) Fetch two-byte handler from pending slot
module vamap_top
  import vamap_pkg::*;
#(
  parameter int RAM_BYTES = `VAMAP_RAM_BYTES
) (
  input  wire logic        pclk,                 // APB clock, 25 MHz
  input  wire logic        presetn,              // Async reset, active low
  input  wire logic        psel,                 // APB select
  input  wire logic        penable,              // APB access phase
  input  wire logic        pwrite,               // APB write
  input  wire logic [11:0] paddr,                // APB byte address
  input  wire logic [31:0] pwdata,               // APB write data
  output logic      [31:0] prdata,               // APB read data
  output logic             pready,               // APB ready
  output logic             pslverr,              // APB error
  input  wire logic [7:0]  external_irq_inputs,  // External interrupt lines
  input  wire logic        suspend_end,          // End of bus suspend event
  input  wire logic        flash_start,          // Flash programming start event
  input  wire logic [15:0] core_addr,            // Core address for decode
  output vamap_port_t      port_a,               // Port A registers
  output vamap_port_t      port_b,               // Port B registers
  output vamap_port_t      port_c,               // Port C registers
  output vamap_port_t      port_d,               // Port D registers
  output vamap_region_t    region,               // Registered region hits
  output logic             vec_valid,            // Vector fetch pending
  output logic [15:0]      vec_addr,             // Slot address, low byte even
  output logic             wake                  // Leave halt
);
  vamap_port_t   pa_reg, pb_reg, pc_reg, pd_reg;
  vamap_region_t region_next;
  vamap_src_t    src_reg, src_next;
  logic          imask_reg, halt_reg, trap_reg, boot_reg;
  logic [7:0]    ext_pend_reg;
  logic          susp_pend_reg, flash_pend_reg;
  logic          wake_next;
  logic [31:0]   rdata_next;
  logic [7:0]    wbyte;
  logic          wr_en, rd_en, addr_ok;

  initial begin
    if (RAM_BYTES < `VAMAP_HWREG_BYTES * 2 || RAM_BYTES > `VAMAP_RAM_BYTES)
      $error("vamap_top: RAM_BYTES out of range");
  end

  function automatic logic [15:0] slot_of(input vamap_src_t s);
    unique case (s)
      VAMAP_SRC_EXT:   slot_of = `VAMAP_VEC_EXT;
      VAMAP_SRC_SUSP:  slot_of = `VAMAP_VEC_SUSP;
      VAMAP_SRC_FLASH: slot_of = `VAMAP_VEC_FLASH;
      VAMAP_SRC_TRAP:  slot_of = `VAMAP_VEC_TRAP;
      VAMAP_SRC_RESET: slot_of = `VAMAP_VEC_RESET;
      VAMAP_SRC_NONE:  slot_of = `VAMAP_VEC_RESET;
    endcase
  endfunction : slot_of

  vamap_decode #(.RAM_BYTES(RAM_BYTES)) u_decode (
    .addr   (core_addr),
    .region (region_next)
  );

  // Zero-wait APB slave; unmapped word addresses answer with pslverr
  assign wr_en   = psel && penable && pwrite && pready && addr_ok;
  assign rd_en   = psel && !penable && !pwrite;
  assign addr_ok = paddr[1:0] == 2'h0 && paddr[11:2] <= 10'(`VAMAP_VEC_OUT);
  assign wbyte   = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // Port registers; port C bit 3 is undefined at reset, cleared here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_reg <= '{value: `VAMAP_PORT_RST, dir: `VAMAP_PORT_RST};  // RULE11
      pb_reg <= '{value: `VAMAP_PORT_RST, dir: `VAMAP_PORT_RST};  // RULE12
      pc_reg <= '{value: `VAMAP_PC_RST, dir: `VAMAP_PC_RST};      // RULE13
      pd_reg <= '{value: `VAMAP_PORT_RST, dir: `VAMAP_PORT_RST};  // RULE14
    end else if (wr_en && addr_ok) begin
      unique case (paddr[11:2])
        10'(`VAMAP_PA_VALUE): pa_reg.value <= wbyte;  // RULE11
        10'(`VAMAP_PA_DIR):   pa_reg.dir   <= wbyte;  // RULE11
        10'(`VAMAP_PB_VALUE): pb_reg.value <= wbyte;  // RULE12
        10'(`VAMAP_PB_DIR):   pb_reg.dir   <= wbyte;  // RULE12
        10'(`VAMAP_PC_VALUE): pc_reg.value <= wbyte;  // RULE13
        10'(`VAMAP_PC_DIR):   pc_reg.dir   <= wbyte;  // RULE13
        10'(`VAMAP_PD_VALUE): pd_reg.value <= wbyte;  // RULE14
        10'(`VAMAP_PD_DIR):   pd_reg.dir   <= wbyte;  // RULE14
        default: ;
      endcase
    end
  end

  // Control register: global mask, halt request, trap strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_reg <= 1'b1;
      trap_reg  <= 1'b0;
    end else begin
      trap_reg <= wr_en && paddr[11:2] == 10'(`VAMAP_CTRL) && wbyte[`VAMAP_CTRL_TRAP];
      if (wr_en && paddr[11:2] == 10'(`VAMAP_CTRL))
        imask_reg <= wbyte[`VAMAP_CTRL_IMASK];
    end
  end

  wire ack_wr = wr_en && paddr[11:2] == 10'(`VAMAP_CTRL) && wbyte[`VAMAP_CTRL_ACK];

  // Pending events; a new event in the ack cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_pend_reg   <= 8'h00;
      susp_pend_reg  <= 1'b0;
      flash_pend_reg <= 1'b0;
    end else begin
      ext_pend_reg   <= ((ack_wr && src_reg == VAMAP_SRC_EXT) ? 8'h00 : ext_pend_reg)
                        | external_irq_inputs;                              // RULE7
      susp_pend_reg  <= ((ack_wr && src_reg == VAMAP_SRC_SUSP) ? 1'b0 : susp_pend_reg)
                        | suspend_end;                                      // RULE8
      flash_pend_reg <= ((ack_wr && src_reg == VAMAP_SRC_FLASH) ? 1'b0 : flash_pend_reg)
                        | flash_start;                                      // RULE9
    end
  end

  // Source priority: reset, trap, flash, suspend, external
  always_comb begin
    src_next  = VAMAP_SRC_NONE;
    wake_next = 1'b0;
    if (boot_reg) begin
      src_next  = VAMAP_SRC_RESET;                                    // RULE6
      wake_next = 1'b1;                                               // RULE6
    end else if (trap_reg && !halt_reg) begin
      src_next  = VAMAP_SRC_TRAP;                                     // RULE10
    end else if (!imask_reg && flash_pend_reg) begin
      src_next  = VAMAP_SRC_FLASH;                                    // RULE9
      wake_next = halt_reg;
    end else if (!imask_reg && susp_pend_reg) begin
      src_next  = VAMAP_SRC_SUSP;                                     // RULE8
      wake_next = halt_reg;
    end else if (!imask_reg && |ext_pend_reg) begin
      src_next  = VAMAP_SRC_EXT;                                      // RULE7
      wake_next = halt_reg;
    end
  end

  // Halt state, entered by software, left by a waking source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_reg <= 1'b0;
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
      if (wake_next)
        halt_reg <= 1'b0;
      else if (wr_en && paddr[11:2] == 10'(`VAMAP_CTRL) && wbyte[`VAMAP_CTRL_HALT])
        halt_reg <= 1'b1;
    end
  end

  // Latched vector held until software acknowledges; the reset vector is re-decided each cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg   <= VAMAP_SRC_NONE;
      vec_valid <= 1'b0;
      vec_addr  <= `VAMAP_VEC_RESET;
      wake      <= 1'b0;
    end else begin
      wake <= wake_next;
      if (ack_wr) begin
        // Release for a cycle so the acknowledged source is not retaken
        src_reg   <= VAMAP_SRC_NONE;
        vec_valid <= 1'b0;
      end else if (src_reg == VAMAP_SRC_NONE || src_reg == VAMAP_SRC_RESET) begin
        src_reg   <= src_next;
        vec_valid <= src_next != VAMAP_SRC_NONE;                      // RULE15
        vec_addr  <= slot_of(src_next);                               // RULE15
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) region <= '0;
    else          region <= region_next;                              // RULE1
  end

  assign port_a = pa_reg;
  assign port_b = pb_reg;
  assign port_c = pc_reg;
  assign port_d = pd_reg;

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (paddr[11:2])
      10'(`VAMAP_PA_VALUE): rdata_next[7:0] = pa_reg.value;
      10'(`VAMAP_PA_DIR):   rdata_next[7:0] = pa_reg.dir;
      10'(`VAMAP_PB_VALUE): rdata_next[7:0] = pb_reg.value;
      10'(`VAMAP_PB_DIR):   rdata_next[7:0] = pb_reg.dir;
      10'(`VAMAP_PC_VALUE): rdata_next[7:0] = pc_reg.value;
      10'(`VAMAP_PC_DIR):   rdata_next[7:0] = pc_reg.dir;
      10'(`VAMAP_PD_VALUE): rdata_next[7:0] = pd_reg.value;
      10'(`VAMAP_PD_DIR):   rdata_next[7:0] = pd_reg.dir;
      10'(`VAMAP_CTRL):     rdata_next[0]   = imask_reg;
      10'(`VAMAP_STATUS):   rdata_next[7:0] = {1'b0, src_reg, 2'b00, halt_reg, vec_valid};
      10'(`VAMAP_VEC_OUT):  rdata_next[15:0] = vec_addr;
      default: ;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (rd_en) prdata <= addr_ok ? rdata_next : 32'h0000_0000;
  end

  // Assertions
  property p_pa_reset;
    @(posedge pclk) $rose(presetn) |-> pa_reg == 16'h0000 && pd_reg == 16'h0000;
  endproperty
  a_pa_reset: assert property (p_pa_reset) else $error("port A/D not zero after reset"); // RULE11

  property p_pb_reset;
    @(posedge pclk) $rose(presetn) |-> pb_reg == 16'h0000;
  endproperty
  a_pb_reset: assert property (p_pb_reset) else $error("port B not zero after reset"); // RULE12

  property p_pc_reset;
    @(posedge pclk) $rose(presetn) |-> pc_reg.value[7:4] == 4'hf && pc_reg.value[2:0] == 3'h0;
  endproperty
  a_pc_reset: assert property (p_pc_reset) else $error("port C reset pattern wrong"); // RULE13

  property p_reset_vec;
    @(posedge pclk) disable iff (!presetn) $rose(presetn) ##1 1 |-> vec_addr == 16'hfffe;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset slot not fetched"); // RULE6

  property p_masked;
    @(posedge pclk) disable iff (!presetn)
      imask_reg && !boot_reg && !trap_reg |-> src_next == VAMAP_SRC_NONE;
  endproperty
  a_masked: assert property (p_masked) else $error("masked source taken"); // RULE7

  property p_trap_slot;
    @(posedge pclk) disable iff (!presetn)
      $changed(src_reg) && src_reg == VAMAP_SRC_TRAP |-> vec_addr == 16'hfffc && !wake;
  endproperty
  a_trap_slot: assert property (p_trap_slot) else $error("trap slot or wake wrong"); // RULE10

  property p_slot_even;
    @(posedge pclk) disable iff (!presetn)
      vec_valid |-> vec_addr[0] == 1'b0 && vec_addr > 16'hffed;
  endproperty
  a_slot_even: assert property (p_slot_even) else $error("slot not a used pair"); // RULE15

  property p_ext_wake;
    @(posedge pclk) disable iff (!presetn)
      halt_reg && !imask_reg && |ext_pend_reg && !boot_reg |=> wake ##1 !halt_reg;
  endproperty
  a_ext_wake: assert property (p_ext_wake) else $error("external did not wake"); // RULE7

  property p_stack;
    @(posedge pclk) disable iff (!presetn)
      core_addr == 16'h0180 |=> !region.stack && region.ram;
  endproperty
  a_stack: assert property (p_stack) else $error("stack window wrong"); // RULE3

  property p_ack_release;
    @(posedge pclk) disable iff (!presetn)
      ack_wr |=> !vec_valid;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("vector held after ack"); // RULE15

  property p_flash_wake;
    @(posedge pclk) disable iff (!presetn)
      halt_reg && !imask_reg && flash_pend_reg && !boot_reg && !ack_wr &&
        src_reg == VAMAP_SRC_NONE |=> wake && vec_addr == 16'hfffa;
  endproperty
  a_flash_wake: assert property (p_flash_wake) else $error("flash start did not wake"); // RULE9

  property p_susp_wake;
    @(posedge pclk) disable iff (!presetn)
      halt_reg && !imask_reg && susp_pend_reg && !flash_pend_reg && !boot_reg && !ack_wr &&
        src_reg == VAMAP_SRC_NONE |=> wake && vec_addr == 16'hfff8;
  endproperty
  a_susp_wake: assert property (p_susp_wake) else $error("suspend end did not wake"); // RULE8

  c_ext:   cover property (@(posedge pclk) src_reg == VAMAP_SRC_EXT);
  c_wake:  cover property (@(posedge pclk) wake && halt_reg);
  c_trap:  cover property (@(posedge pclk) src_reg == VAMAP_SRC_TRAP);
  c_ack:   cover property (@(posedge pclk) ack_wr && vec_valid);
endmodule : vamap_top
`default_nettype wire

//--- tb/vamap_core_model.sv
// Stand-in for the CPU core: drives the decode address, fetches handler slots.
// Assumes the map block's vector outputs share pclk and presetn.
`timescale 1ns/1ps
`default_nettype none
module vamap_core_model (
  input  wire logic        pclk,       // System clock
  input  wire logic        presetn,    // Async reset, active low
  input  wire logic [15:0] want_addr,  // Address the bench wants decoded
  input  wire logic        vec_valid,  // Vector pending
  input  wire logic [15:0] vec_addr,   // Pending slot address
  output logic      [15:0] core_addr,  // Address to the map block
  output var int           fetches     // Slot bytes fetched so far
);
  logic [1:0]  step_reg;
  logic [15:0] slot_reg;

  // Restart on a new slot, since a chained vector may keep valid high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_reg <= 2'h0;
      slot_reg <= 16'h0000;
      fetches  <= 0;
    end else if (!vec_valid || vec_addr != slot_reg) begin
      step_reg <= 2'h0;
      slot_reg <= vec_addr;
    end else if (step_reg != 2'h2) begin
      step_reg <= step_reg + 2'h1;
      fetches  <= fetches + 1;
    end
  end

  // Two handler bytes from the pending slot only, never a reserved place
  assign core_addr = (vec_valid && vec_addr == slot_reg && step_reg != 2'h2) ?
                     {vec_addr[15:1], step_reg[0]} : want_addr;
endmodule : vamap_core_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the vector and address map block.
// Assumes vamap_top and the core stand-in; the APB master runs on pclk.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vamap_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic          suspend_end, flash_start, vec_valid, wake, er;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd, d;
  logic [7:0]    external_irq_inputs;
  logic [15:0]   core_addr, want_addr, vec_addr;
  vamap_port_t   port_a, port_b, port_c, port_d;
  vamap_region_t region;
  int            failures, comparisons, seed, wakes, fetches, f0;
  int            regs[8];
  logic [15:0]   vexp[3] = '{16'hfff6, 16'hfff8, 16'hfffa};
  logic [19:0]   rt[11] = '{20'h003f8, 20'h00400, 20'h00ff0, 20'h01004, 20'h017f4,
                            20'h01800, 20'hffdf0, 20'hffe03, 20'hffed3, 20'hffee2, 20'hffff2};

  vamap_top #(.RAM_BYTES(1024)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_irq_inputs(external_irq_inputs),
    .suspend_end(suspend_end), .flash_start(flash_start), .core_addr(core_addr),
    .port_a(port_a), .port_b(port_b), .port_c(port_c), .port_d(port_d), .region(region),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .wake(wake));
  vamap_core_model CORE (.pclk(pclk), .presetn(presetn), .want_addr(want_addr),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .core_addr(core_addr), .fetches(fetches));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (wake === 1'b1) wakes <= wakes + 1;

  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic chk_vec(input logic v, input logic [15:0] a);
    comparisons++;
    if (vec_valid !== v || (v && vec_addr !== a)) begin
      failures++;
      $display("[ERR] %0t vector %b %h exp %b %h", $time, vec_valid, vec_addr, v, a);
    end
  endtask : chk_vec
  task automatic hang(input string m);
    failures++;
    $display("[ERR] %0t timeout in %s", $time, m);
    end_sim;
  endtask : hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang("apb");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic ctrl(input logic [7:0] v);
    apb(1'b1, 12'h020, {24'h0, v});
  endtask : ctrl
  // Acknowledge while keeping the mask bit as given
  task automatic ack(input logic m);
    ctrl({7'h04, m});
    repeat (3) @(posedge pclk);
  endtask : ack
  task automatic wait_vec;
    int n;
    n = 0;
    while (vec_valid !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (vec_valid !== 1'b1) hang("vector wait");
  endtask : wait_vec
  task automatic pulse(input int k);
    @(posedge pclk);
    if (k == 0) external_irq_inputs <= 8'($random(seed)) | 8'h01;
    suspend_end <= (k == 1);
    flash_start <= (k == 2);
    @(posedge pclk);
    external_irq_inputs <= 8'h00;
    suspend_end <= 1'b0;
    flash_start <= 1'b0;
  endtask : pulse
  task automatic reset_dut;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk_vec(1'b1, 16'hfffe);
    chk({31'h0, wake}, 32'h1, "reset wake");
  endtask : reset_dut
  task automatic rst_chk;
    for (int i = 0; i < 8; i++) begin
      regs[i] = (i == 4 || i == 5) ? 8'hf0 : 8'h00;
      apb(1'b0, 12'(4 * i), 32'h0);
      chk({24'h0, rd[7:0]}, 32'(regs[i]), "reset value");
    end
  endtask : rst_chk
  task automatic ports_chk;
    chk({16'h0, port_a}, {16'h0, 8'(regs[0]), 8'(regs[1])}, "port a");
    chk({16'h0, port_b}, {16'h0, 8'(regs[2]), 8'(regs[3])}, "port b");
    chk({16'h0, port_c}, {16'h0, 8'(regs[4]), 8'(regs[5])}, "port c");
    chk({16'h0, port_d}, {16'h0, 8'(regs[6]), 8'(regs[7])}, "port d");
  endtask : ports_chk

  initial begin
    #2000000;
    hang("run");
  end

  initial begin
    {presetn, psel, penable, pwrite, suspend_end, flash_start} = 6'h00;
    {paddr, pwdata, external_irq_inputs, want_addr} = '0;
    {failures, comparisons} = '0;
    seed = 46;
    reset_dut;
    rst_chk;
    ports_chk;
    $display("test reset values done");
    for (int i = 0; i < 11; i++) begin
      want_addr <= rt[i][19:4];
      repeat (2) @(posedge pclk);
      chk({28'h0, region.hwreg, region.stack, region.vec, region.vec_rsvd},
          {28'h0, rt[i][3:0]}, "region");
      chk({31'h0, region.prog}, 32'(rt[i][19] && !rt[i][1]), "program");
    end
    for (int k = 0; k < 2; k++) begin
      want_addr <= 16'h03ff + 16'(k);
      repeat (2) @(posedge pclk);
      chk({31'h0, region.ram}, 32'(k == 0), "ram edge");
    end
    $display("test decode done");
    ctrl(8'h01);
    for (int k = 0; k < 3; k++) pulse(k);
    repeat (6) @(posedge pclk);
    chk_vec(1'b0, 16'h0000);
    ctrl(8'h05);
    wait_vec;
    chk_vec(1'b1, 16'hfffc);
    apb(1'b0, 12'h024, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h41, "status");
    apb(1'b0, 12'h028, 32'h0);
    chk({16'h0, rd[15:0]}, 32'hfffc, "slot read");
    ack(1'b1);
    chk_vec(1'b0, 16'h0000);
    f0 = fetches;
    ctrl(8'h00);
    for (int k = 2; k >= 0; k--) begin
      wait_vec;
      chk_vec(1'b1, vexp[k]);
      ack(1'b0);
    end
    chk(32'(fetches - f0), 32'h6, "slot fetches");
    $display("test vectors done");
    f0 = wakes;
    ctrl(8'h02);
    ctrl(8'h06);
    repeat (4) @(posedge pclk);
    chk_vec(1'b0, 16'h0000);
    chk(32'(wakes - f0), 32'h0, "trap wake");
    for (int k = 0; k < 3; k++) begin
      ctrl(8'h02);
      pulse(k);
      wait_vec;
      chk_vec(1'b1, vexp[k]);
      repeat (2) @(posedge pclk);
      chk(32'(wakes - f0), 32'(k + 1), "halt wake");
      ack(1'b0);
    end
    $display("test halt done");
    for (int r = 0; r < 16; r++) begin
      d = $random(seed);
      apb(1'b1, 12'(4 * (r % 8)), d);
      regs[r % 8] = d[7:0];
      chk({31'h0, er}, 32'h0, "write error");
    end
    apb(1'b1, 12'h02c, 32'hff);
    chk({31'h0, er}, 32'h1, "unmapped write");
    apb(1'b1, 12'h001, 32'hff);
    chk({31'h0, er}, 32'h1, "unaligned write");
    apb(1'b0, 12'h02c, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000, "unmapped read");
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk({24'h0, rd[7:0]}, 32'(regs[i]), "read back");
    end
    ports_chk;
    $display("test registers done");
    reset_dut;
    rst_chk;
    ports_chk;
    $display("test second reset done");
    end_sim;
  end
endmodule : testbench
`default_nettype wire
